// ===== rmlc_pkg.sv
// shared constants, types and decode functions for the monitor limit block
package rmlc_pkg;

  // ---------------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------------
  localparam int          ADDR_W      = 7;      // register address width
  localparam int          DATA_W      = 8;      // register data width
  localparam logic [6:0]  ADDR_IN2    = 7'h4d;  // input_two_monitor_limits
  localparam logic [6:0]  ADDR_IN3    = 7'h4e;  // input_three_monitor_limits
  localparam logic [6:0]  ADDR_LOOP   = 7'h4f;  // loop_select_config
  localparam logic [7:0]  RST_IN2     = 8'h55;  // reset of input two limits
  localparam logic [7:0]  RST_IN3     = 8'h55;  // reset of input three limits
  localparam logic [7:0]  RST_LOOP    = 8'hf2;  // reset of loop selection
  localparam logic [7:0]  RDATA_NONE  = 8'h00;  // answer to unmapped reads

  // ---------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------
  localparam int CFM_LSB  = 0;  // coarse limit, bits 2:0
  localparam int SCM_LSB  = 4;  // single-cycle limit, bits 6:4
  localparam int LOOP_LSB = 0;  // loop selection, bits 1:0
  localparam int PACQ_LSB = 4;  // phase acquisition enables, bits 7:4
  localparam int CODE_W   = 3;  // width of a limit code
  localparam int PACQ_N   = 4;  // number of phase acquisition modules
  localparam int REF_N    = 2;  // monitored references

  // ---------------------------------------------------------------------
  // tolerances in units of 0.1 percent
  // ---------------------------------------------------------------------
  localparam logic [9:0]  TOL_0P1  = 10'h001;  // 0.1 %
  localparam logic [9:0]  TOL_0P5  = 10'h005;  // 0.5 %
  localparam logic [9:0]  TOL_1    = 10'h00a;  // 1 %
  localparam logic [9:0]  TOL_2    = 10'h014;  // 2 %
  localparam logic [9:0]  TOL_5    = 10'h032;  // 5 %
  localparam logic [9:0]  TOL_10   = 10'h064;  // 10 %
  localparam logic [9:0]  TOL_20   = 10'h0c8;  // 20 %
  localparam logic [9:0]  TOL_50   = 10'h1f4;  // 50 %
  localparam logic [31:0] TOL_DEN  = 32'h000003e8; // 1000 units = 100 %

  // ---------------------------------------------------------------------
  // sampling resolution of the period measurement
  // ---------------------------------------------------------------------
  localparam int SAMPLE_CLK_MHZ = 800;                      // sampler rate
  localparam int SAMPLE_RES_PS  = 1000000 / SAMPLE_CLK_MHZ; // 1250 ps
  localparam int CLK_MHZ        = 50;                       // block clock
  localparam int CLK_PERIOD_PS  = 1000000 / CLK_MHZ;        // 20000 ps

  // ---------------------------------------------------------------------
  // types
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic             wr;     // one-cycle write strobe
    logic             rd;     // one-cycle read strobe
    logic [6:0]       addr;   // register address
    logic [7:0]       wdata;  // write data
  } rmlc_req_s;

  typedef enum logic [2:0] {
    LOOP_NONE  = 3'b001,  // no loop runs
    LOOP_FIRST = 3'b010,  // first loop only
    LOOP_BOTH  = 3'b100   // first and second loop
  } rmlc_loop_e;

  // single-cycle code to tolerance; 110/111 are undefined, held at widest
  function automatic logic [9:0] scm_tol(input logic [2:0] code);
    case (code)
      3'h0:    scm_tol = TOL_0P1;
      3'h1:    scm_tol = TOL_0P5;
      3'h2:    scm_tol = TOL_1;
      3'h3:    scm_tol = TOL_2;
      3'h4:    scm_tol = TOL_5;
      default: scm_tol = TOL_50;
    endcase
  endfunction

  // coarse code to tolerance, 0.1 % through 50 %
  function automatic logic [9:0] cfm_tol(input logic [2:0] code);
    case (code)
      3'h0:    cfm_tol = TOL_0P1;
      3'h1:    cfm_tol = TOL_0P5;
      3'h2:    cfm_tol = TOL_1;
      3'h3:    cfm_tol = TOL_2;
      3'h4:    cfm_tol = TOL_5;
      3'h5:    cfm_tol = TOL_10;
      3'h6:    cfm_tol = TOL_20;
      default: cfm_tol = TOL_50;
    endcase
  endfunction

endpackage

// ===== rmlc_ref_mon.sv
// period and coarse frequency monitor for one reference input
`timescale 1ns/1ps
module rmlc_ref_mon
  import rmlc_pkg::*;
#(
  parameter int unsigned NOM_PERIOD = 50,    // sample ticks per ref period
  parameter int unsigned CFM_WIN    = 1000,  // sample ticks per window
  parameter int unsigned CW         = 16     // counter width
)(
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic              ref_in,     // asynchronous reference
  input  wire logic [CODE_W-1:0] scm_code,   // single-cycle limit code
  input  wire logic [CODE_W-1:0] cfm_code,   // coarse limit code
  output logic                   scm_fail,   // period out of tolerance
  output logic                   cfm_fail    // frequency out of tolerance
);

  // ---------------------------------------------------------------------
  // synchroniser and edge detect
  // ---------------------------------------------------------------------
  logic          ref_s1_r;     // first stage, read only by second
  logic          ref_s2_r;     // second stage
  logic          ref_s3_r;     // edge history
  logic          rise;         // rising edge of the reference
  logic [CW-1:0] per_cnt_r;    // ticks since last rising edge
  logic          armed_r;      // one edge seen, periods measurable
  logic [CW-1:0] edge_cnt_r;   // edges inside the coarse window
  logic [CW-1:0] win_cnt_r;    // position inside the coarse window
  logic [31:0]   scm_dlt;      // allowed period deviation in ticks
  logic [31:0]   scm_lo;       // shortest legal period
  logic [31:0]   scm_hi;       // longest legal period
  logic [31:0]   nom_edges;    // expected edges per window
  logic [31:0]   cfm_dlt;      // allowed edge count deviation
  logic [31:0]   edges_now;    // window edge total including this cycle
  logic          win_end;      // last tick of the coarse window

  // the first stage never feeds logic, so metastability stays contained
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ref_s1_r <= 1'b0;
      ref_s2_r <= 1'b0;
      ref_s3_r <= 1'b0;
    end
    else
    begin
      ref_s1_r <= ref_in;
      ref_s2_r <= ref_s1_r;
      ref_s3_r <= ref_s2_r;
    end
  end

  assign rise = ref_s2_r & ~ref_s3_r;

  // ---------------------------------------------------------------------
  // single-cycle bounds
  // ---------------------------------------------------------------------
  // division by a constant; area traded for a per-code lookup table
  assign scm_dlt = (32'(NOM_PERIOD) * 32'(scm_tol(scm_code))) / TOL_DEN;
  assign scm_lo  = 32'(NOM_PERIOD) - scm_dlt;
  assign scm_hi  = 32'(NOM_PERIOD) + scm_dlt;

  // period counter, saturating so a dead reference stays failed
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      per_cnt_r <= '0;
    else if (rise)
      per_cnt_r <= CW'(1);
    else if (per_cnt_r != '1)
      per_cnt_r <= per_cnt_r + CW'(1);
  end

  // measurement starts after the first edge, a partial period is no period
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      armed_r <= 1'b0;
    else if (rise)
      armed_r <= 1'b1;
  end

  // failure level, re-judged at each edge and on an overlong period
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      scm_fail <= 1'b0;
    else if (armed_r && rise)
      scm_fail <= (32'(per_cnt_r) < scm_lo) ||
                  (32'(per_cnt_r) > scm_hi);
    else if (armed_r && (32'(per_cnt_r) > scm_hi))
      scm_fail <= 1'b1;
  end

  // ---------------------------------------------------------------------
  // coarse frequency window
  // ---------------------------------------------------------------------
  assign nom_edges = 32'(CFM_WIN) / 32'(NOM_PERIOD);
  assign cfm_dlt   = (nom_edges * 32'(cfm_tol(cfm_code))) / TOL_DEN;
  assign edges_now = 32'(edge_cnt_r) + 32'(rise);
  assign win_end   = (32'(win_cnt_r) == 32'(CFM_WIN) - 32'h1);

  // window position and edge tally
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      win_cnt_r  <= '0;
      edge_cnt_r <= '0;
    end
    else if (win_end)
    begin
      win_cnt_r  <= '0;
      edge_cnt_r <= '0;
    end
    else
    begin
      win_cnt_r  <= win_cnt_r + CW'(1);
      edge_cnt_r <= edge_cnt_r + CW'(rise);
    end
  end

  // coarse verdict held for the whole next window
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      cfm_fail <= 1'b0;
    else if (win_end)
      cfm_fail <= (edges_now + cfm_dlt < nom_edges) ||
                  (edges_now > nom_edges + cfm_dlt);
  end

  // ---------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------
  property overrun_p;
    @(posedge clk) disable iff (!arst_n)
      (armed_r && !rise && (32'(per_cnt_r) > scm_hi)) |=> scm_fail;
  endproperty
  scm_overrun_a: assert property (overrun_p)
    else $error("period overrun did not raise the cycle failure");

  property short_p;
    @(posedge clk) disable iff (!arst_n)
      (armed_r && rise && (32'(per_cnt_r) < scm_lo)) |=> scm_fail;
  endproperty
  scm_short_a: assert property (short_p)
    else $error("short period did not raise the cycle failure");

  property cfm_hold_p;
    @(posedge clk) disable iff (!arst_n)
      !win_end |=> $stable(cfm_fail);
  endproperty
  cfm_hold_a: assert property (cfm_hold_p)
    else $error("coarse failure changed inside a window");

endmodule // rmlc_ref_mon

// ===== rmlc_top.sv
// monitor limit registers, loop selection and per-reference monitors
`timescale 1ns/1ps
//
// Function
// - decode single-cycle code into period tolerance
// - flag reference periods outside cycle tolerance
// - decode coarse code 0.1 to 50 percent
// - flag frequency outside coarse tolerance
// - period measured in block clock ticks, 20 ns
// - loop field selects none, first, both
// - bits 7:4 enable phase acquisition modules
module rmlc_top
  import rmlc_pkg::*;
#(
  parameter int unsigned NOM_PERIOD_2 = 50,   // input two nominal ticks
  parameter int unsigned NOM_PERIOD_3 = 50,   // input three nominal ticks
  parameter int unsigned CFM_WIN      = 1000, // coarse window in ticks
  parameter int unsigned CW           = 16    // monitor counter width
)(
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire rmlc_req_s         host_req,       // decoded host port access
  output logic [DATA_W-1:0]      host_rdata,     // read data, registered
  output logic                   host_rvalid,    // read data valid pulse
  input  wire logic [REF_N-1:0]  ref_in,         // references two and three
  output logic [REF_N-1:0]       scm_fail,       // single-cycle failures
  output logic [REF_N-1:0]       cfm_fail,       // coarse failures
  output logic                   first_loop_en,  // first loop running
  output logic                   second_loop_en, // second loop running
  output logic [PACQ_N-1:0]      phase_acq_en    // acquisition module power
);

  // ---------------------------------------------------------------------
  // register storage
  // ---------------------------------------------------------------------
  logic [DATA_W-1:0] in2_lim_r;    // input_two_monitor_limits
  logic [DATA_W-1:0] in3_lim_r;    // input_three_monitor_limits
  logic [DATA_W-1:0] loop_cfg_r;   // loop_select_config
  logic              wr_in2;       // write hits input two limits
  logic              wr_in3;       // write hits input three limits
  logic              wr_loop;      // write hits loop selection
  logic [DATA_W-1:0] rdata_nxt;    // read mux output

  assign wr_in2  = host_req.wr && (host_req.addr == ADDR_IN2);
  assign wr_in3  = host_req.wr && (host_req.addr == ADDR_IN3);
  assign wr_loop = host_req.wr && (host_req.addr == ADDR_LOOP);

  // input two limits; reserved bits kept as written so reads echo them
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      in2_lim_r <= RST_IN2;
    else if (wr_in2)
      in2_lim_r <= host_req.wdata;
  end

  // input three limits
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      in3_lim_r <= RST_IN3;
    else if (wr_in3)
      in3_lim_r <= host_req.wdata;
  end

  // loop selection and acquisition enables
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      loop_cfg_r <= RST_LOOP;
    else if (wr_loop)
      loop_cfg_r <= host_req.wdata;
  end

  // ---------------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------------
  // unmapped addresses answer zero rather than floating
  always_comb
  begin
    case (host_req.addr)
      ADDR_IN2:  rdata_nxt = in2_lim_r;
      ADDR_IN3:  rdata_nxt = in3_lim_r;
      ADDR_LOOP: rdata_nxt = loop_cfg_r;
      default:   rdata_nxt = RDATA_NONE;
    endcase
  end

  // read data captured one cycle after the strobe
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      host_rdata  <= RDATA_NONE;
      host_rvalid <= 1'b0;
    end
    else
    begin
      host_rvalid <= host_req.rd;
      if (host_req.rd)
        host_rdata <= rdata_nxt;
    end
  end

  // ---------------------------------------------------------------------
  // loop activation
  // ---------------------------------------------------------------------
  rmlc_loop_e loop_mode;  // decoded loop selection

  // the reserved code runs no loop, the safe choice for an illegal write
  always_comb
  begin
    case (loop_cfg_r[LOOP_LSB +: 2])
      2'h1:    loop_mode = LOOP_FIRST;
      2'h2:    loop_mode = LOOP_BOTH;
      default: loop_mode = LOOP_NONE;
    endcase
  end

  // registered enables so no decode glitch reaches the loops
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      first_loop_en  <= 1'b0;
      second_loop_en <= 1'b0;
    end
    else
    begin
      first_loop_en  <= (loop_mode == LOOP_FIRST) ||
                        (loop_mode == LOOP_BOTH);
      second_loop_en <= (loop_mode == LOOP_BOTH);
    end
  end

  // ---------------------------------------------------------------------
  // phase acquisition power
  // ---------------------------------------------------------------------
  // a cleared bit powers its module down; bit 4 is module 0
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      phase_acq_en <= '0;
    else
      phase_acq_en <= loop_cfg_r[PACQ_LSB +: PACQ_N];
  end

  // ---------------------------------------------------------------------
  // reference monitors
  // ---------------------------------------------------------------------
  logic [REF_N-1:0][CODE_W-1:0] scm_code;  // per-reference cycle codes
  logic [REF_N-1:0][CODE_W-1:0] cfm_code;  // per-reference coarse codes
  logic [CODE_W-1:0] input_two_cycle_tolerance;   // input two cycle code
  logic [CODE_W-1:0] input_three_cycle_tolerance; // input three cycle code
  logic [CODE_W-1:0] input_three_freq_tolerance;  // input three coarse code

  assign input_two_cycle_tolerance   = in2_lim_r[SCM_LSB +: CODE_W];
  assign input_three_cycle_tolerance = in3_lim_r[SCM_LSB +: CODE_W];
  assign input_three_freq_tolerance  = in3_lim_r[CFM_LSB +: CODE_W];
  assign scm_code[0] = input_two_cycle_tolerance;
  assign scm_code[1] = input_three_cycle_tolerance;
  assign cfm_code[0] = in2_lim_r[CFM_LSB +: CODE_W];
  assign cfm_code[1] = input_three_freq_tolerance;

  // the cycle flag stays live above 400 MHz; masking it is up to software
  genvar gi;
  generate
    for (gi = 0; gi < REF_N; gi++)
    begin : g_mon
      rmlc_ref_mon #(
        .NOM_PERIOD (gi == 0 ? NOM_PERIOD_2 : NOM_PERIOD_3),
        .CFM_WIN    (CFM_WIN),
        .CW         (CW)
      ) u_mon (
        .clk      (clk),
        .arst_n   (arst_n),
        .ref_in   (ref_in[gi]),
        .scm_code (scm_code[gi]),
        .cfm_code (cfm_code[gi]),
        .scm_fail (scm_fail[gi]),
        .cfm_fail (cfm_fail[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence loop_held(logic [1:0] code);
    (loop_cfg_r[1:0] == code) [*2];
  endsequence

  sequence loop_write;
    wr_loop ##1 1'b1;
  endsequence

  cyc_write_a: assert property (
    wr_in2 |=> input_two_cycle_tolerance == $past(host_req.wdata[6:4]))
    else $error("cycle code not taken from write");

  freq_write_a: assert property (
    wr_in3 |=> input_three_freq_tolerance == $past(host_req.wdata[2:0]))
    else $error("coarse code not taken from write");

  loop_none_a: assert property (
    loop_held(2'h0) |-> !first_loop_en && !second_loop_en)
    else $error("a loop runs with none selected");

  loop_first_a: assert property (
    loop_held(2'h1) |-> first_loop_en && !second_loop_en)
    else $error("first-only selection not applied");

  loop_both_a: assert property (
    loop_held(2'h2) |-> first_loop_en && second_loop_en)
    else $error("both-loop selection not applied");

  loop_rsvd_a: assert property (
    loop_held(2'h3) |-> !first_loop_en && !second_loop_en)
    else $error("reserved selection started a loop");

  pacq_write_a: assert property (
    loop_write |=> phase_acq_en == $past(host_req.wdata[7:4], 2))
    else $error("acquisition enables do not follow write");

  read_back_a: assert property (host_req.rd |=> host_rvalid &&
                 host_rdata == $past(rdata_nxt))
    else $error("read data wrong or late");

  unmapped_a: assert property ((host_req.rd && host_req.addr != ADDR_IN2 &&
                host_req.addr != ADDR_IN3 && host_req.addr != ADDR_LOOP)
                |=> host_rdata == RDATA_NONE)
    else $error("unmapped read not zero");

endmodule // rmlc_top

// ===== rmlc_top_tb_top.sv
// self-checking testbench for the monitor limit register block
`timescale 1ns/1ps
module rmlc_top_tb_top
  import rmlc_pkg::*;
;
  // ---------------------------------------------------------------------
  // settings and signals
  // ---------------------------------------------------------------------
  localparam int NOM = 10;   // nominal ticks, short so windows stay brief
  localparam int WIN = 100;  // coarse window, gives ten nominal edges

  logic                  clk;             // 50 MHz block clock
  logic                  arst_n;          // asynchronous reset, low active
  rmlc_req_s             host_req;        // register access request
  logic [DATA_W-1:0]     host_rdata;      // read data
  logic                  host_rvalid;     // read data valid
  logic [REF_N-1:0]      ref_in;          // references two and three
  logic [REF_N-1:0]      scm_fail;        // single-cycle failures
  logic [REF_N-1:0]      cfm_fail;        // coarse failures
  logic                  first_loop_en;   // first loop running
  logic                  second_loop_en;  // second loop running
  logic [PACQ_N-1:0]     phase_acq_en;    // acquisition enables
  int                    error_cnt;       // mismatches seen
  int                    n_tests;         // comparisons made
  int                    per [REF_N] = '{10, 10};  // ref periods in ticks
  int                    cnt [REF_N] = '{0, 0};    // ref phase counters
  // tolerance per code in 0.1 % units, coarse meaning of each code
  int                    tol_tab [8] = '{1, 5, 10, 20, 50, 100, 200, 500};

  // ---------------------------------------------------------------------
  // design under test
  // ---------------------------------------------------------------------
  rmlc_top #(
    .NOM_PERIOD_2 (NOM),
    .NOM_PERIOD_3 (NOM),
    .CFM_WIN      (WIN),
    .CW           (16)
  ) i_rmlc_top (
    .clk            (clk),
    .arst_n         (arst_n),
    .host_req       (host_req),
    .host_rdata     (host_rdata),
    .host_rvalid    (host_rvalid),
    .ref_in         (ref_in),
    .scm_fail       (scm_fail),
    .cfm_fail       (cfm_fail),
    .first_loop_en  (first_loop_en),
    .second_loop_en (second_loop_en),
    .phase_acq_en   (phase_acq_en)
  );

  // ---------------------------------------------------------------------
  // clock, references and watchdog
  // ---------------------------------------------------------------------
  // free running clock, 20 ns period
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // references change on the falling edge; duty about one half
  always @(negedge clk)
  begin
    for (int i = 0; i < REF_N; i++)
    begin
      cnt[i] = (cnt[i] + 1 >= per[i]) ? 0 : cnt[i] + 1;
      ref_in[i] <= (cnt[i] < per[i] / 2);
    end
  end

  // a hang is cut short here instead of running forever
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    $display("[ERR] run length expected done seen hang");
    give_verdict();
  end

  // ---------------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------------
  // one compare for all results, bits are zero extended by the caller
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one-cycle write strobe, released a cycle later
  task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk);
    host_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk);
    host_req = '0;
  endtask

  // one-cycle read strobe, then a bounded wait for the valid pulse
  task automatic rd_reg(input logic [6:0] a, output logic [7:0] d);
    @(negedge clk);
    host_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk);
    host_req = '0;
    for (int i = 0; i < 4 && host_rvalid !== 1'b1; i++) @(negedge clk);
    if (host_rvalid !== 1'b1)
    begin
      error_cnt++;
      $display("[ERR] read valid expected 1 seen 0");
      give_verdict();
    end
    else
      d = host_rdata;
  endtask

  // prints the counts and the verdict, then stops
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ---------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------
  // reset values of all registers and of the derived enables
  task automatic t_reset();
    logic [7:0] d;
    rd_reg(ADDR_IN2, d);
    chk("input two limits", 8'h55, d);
    rd_reg(ADDR_IN3, d);
    chk("input three limits", 8'h55, d);
    rd_reg(ADDR_LOOP, d);
    chk("loop select", 8'hf2, d);
    d = {phase_acq_en, 2'b00, second_loop_en, first_loop_en};
    chk("enables", 8'hf3, d);
  endtask

  // reserved bits kept, unmapped places harmless and read as zero
  task automatic t_regs();
    logic [7:0] d;
    wr_reg(ADDR_IN3, 8'haa);
    rd_reg(ADDR_IN3, d);
    chk("input three readback", 8'haa, d);
    wr_reg(7'h10, 8'hff);
    rd_reg(7'h10, d);
    chk("unmapped read", 8'h00, d);
    rd_reg(ADDR_IN2, d);
    chk("input two untouched", 8'h55, d);
  endtask

  // every loop code with a different acquisition pattern each time
  task automatic t_loop();
    logic [7:0] d;
    logic [3:0] pa;
    logic       f;
    logic       s;
    for (int c = 0; c < 4; c++)
    begin
      pa = 4'(c * 5);
      f = (c == 1 || c == 2);
      s = (c == 2);
      wr_reg(ADDR_LOOP, {pa, 2'b00, 2'(c)});
      // enables follow the register one cycle late
      repeat (2) @(negedge clk);
      d = {phase_acq_en, 2'b00, second_loop_en, first_loop_en};
      chk("loop enables", {pa, 2'b00, s, f}, d);
      rd_reg(ADDR_LOOP, d);
      chk("loop readback", {pa, 2'b00, 2'(c)}, d);
    end
  endtask

  // exact nominal periods never fail, even at the tightest code
  task automatic t_nominal();
    per = '{NOM, NOM};
    wr_reg(ADDR_IN2, 8'h00);
    wr_reg(ADDR_IN3, 8'h00);
    repeat (3 * WIN) @(negedge clk);
    chk("scm nominal", 8'h00, {6'h00, scm_fail});
    chk("cfm nominal", 8'h00, {6'h00, cfm_fail});
  endtask

  // slow ref two and fast ref three against every code; frequencies
  // kept low enough that each tolerance is a legal choice
  task automatic t_codes();
    int  dlt;
    int  st;
    per = '{13, 7};
    for (int c = 0; c < 8; c++)
    begin
      wr_reg(ADDR_IN2, {1'b0, 3'(c), 1'b0, 3'(c)});
      wr_reg(ADDR_IN3, {1'b0, 3'(c), 1'b0, 3'(c)});
      repeat (3 * WIN) @(negedge clk);
      // both refs are three ticks off nominal
      st = (c == 5) ? 500 : tol_tab[c];
      dlt = NOM * st / 1000;
      if (c < 6)
        chk("scm code", {6'h00, {2{3 > dlt}}}, {6'h00, scm_fail});
      // ref three gives 14 or 15 edges where 10 are expected
      dlt = (WIN / NOM) * tol_tab[c] / 1000;
      chk("cfm code", {7'h00, 4 > dlt}, {7'h00, cfm_fail[1]});
    end
  endtask

  // ---------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------
  initial
  begin
    arst_n = 1'b0;
    host_req = '0;
    error_cnt = 0;
    n_tests = 0;
    repeat (12) @(negedge clk);
    arst_n = 1'b1;
    t_reset();
    t_regs();
    t_loop();
    t_nominal();
    t_codes();
    give_verdict();
  end

endmodule // rmlc_top_tb_top
